// File: fpe_pkg.sv
package fpe_pkg;

  // register map
  localparam logic [15:0] CONTROL_ADDR       = 16'hfe08;
  localparam logic [15:0] PROTECT_ADDR       = 16'hfe09;
  localparam logic [7:0]  PROTECT_RESET      = 8'h00;
  localparam logic [7:0]  CONTROL_RESET      = 8'h00;

  // control fields
  localparam int          PROG_BIT           = 0;
  localparam int          ERASE_BIT          = 1;
  localparam int          MASS_BIT           = 2;
  localparam int          HIGH_VOLTAGE_ENABLE_BIT           = 3;

  // array layout
  localparam logic [15:0] MAIN_LO            = 16'hba00;
  localparam logic [15:0] MAIN_HI            = 16'hf9ff;
  localparam logic [15:0] VEC_LO             = 16'hffd0;
  localparam logic [15:0] VEC_HI             = 16'hffff;
  localparam int          MAIN_BYTES         = 16384;
  localparam int          VEC_BYTES          = 48;
  localparam int          ARRAY_BYTES        = MAIN_BYTES + VEC_BYTES;
  localparam int          BLOCK_SHIFT        = 9;
  localparam int          ROW_SHIFT          = 6;
  localparam logic [7:0]  ERASED_BYTE        = 8'hff;
  localparam logic [7:0]  PROTECT_NONE       = 8'hff;

  // timing
  localparam int          CLOCK_MHZ          = 10;
  localparam int          RECOVERY_NS        = 1000;
  localparam int          RECOVERY_CYCLES    = (RECOVERY_NS * CLOCK_MHZ + 999) / 1000;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fpe_bus_type;

  typedef enum logic [1:0] {
    FPE_OP_NONE,
    FPE_OP_PROGRAM,
    FPE_OP_BLOCK,
    FPE_OP_MASS
  } fpe_op_type;

endpackage

// File: fpe_protect.sv
`timescale 1ns/10ps
module fpe_protect
  import fpe_pkg::*;
(
  input  wire logic [7:0]  protect_start_bits,  // protect register value
  input  wire logic [15:0] target_addr,         // latched target address
  output logic             target_protected     // target falls in protected range
);

  logic [15:0] start_addr;

  // (RULE17) start address from bits 7..1
  assign start_addr = {protect_start_bits[7:1], 9'h000};

  // (RULE18) all ones disables, zero covers all
  always_comb begin
    if (protect_start_bits == PROTECT_NONE) begin
      target_protected = 1'b0;
    end else begin
      target_protected = (target_addr >= start_addr);
    end
  end

endmodule

// File: fpe_array.sv
`timescale 1ns/10ps
module fpe_array
  import fpe_pkg::*;
#(
  parameter int DEPTH = ARRAY_BYTES
) (
  input  wire logic        clock,        // system clock
  input  wire logic        reset,        // synchronous reset, active high
  input  wire logic        rd_en,        // read strobe
  input  wire logic [15:0] rd_addr,      // read address
  output logic [7:0]       rd_data,      // registered read data
  input  wire logic        prog_en,      // program one byte
  input  wire logic [15:0] prog_addr,    // byte address
  input  wire logic [7:0]  prog_data,    // byte to program
  input  wire logic        erase_en,     // one-cycle erase pulse
  input  wire logic        erase_mass,   // clear everything
  input  wire logic [15:0] erase_addr    // address inside block
);

  logic [7:0] cells_q [DEPTH];

  function automatic int index_of(input logic [15:0] a);
    if (a >= VEC_LO) begin
      index_of = MAIN_BYTES + int'(a - VEC_LO);
    end else begin
      index_of = int'(a - MAIN_LO);
    end
  endfunction

  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= MAIN_LO && a <= MAIN_HI) || (a >= VEC_LO);
  endfunction

  // (RULE1) erased cells read one, programming only clears bits
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      // (RULE2) unmapped holes read as erased
      rd_data <= in_array(rd_addr) ? cells_q[index_of(rd_addr)] : ERASED_BYTE;
    end
  end

  always_ff @(posedge clock) begin
    if (erase_en) begin
      for (int i = 0; i < DEPTH; i++) begin
        // (RULE3) block erase on 512-byte block
        if (erase_mass || (i < MAIN_BYTES &&
            ((MAIN_LO + 16'(i)) >> BLOCK_SHIFT) == (erase_addr >> BLOCK_SHIFT))) begin
          cells_q[i] <= ERASED_BYTE;
        end
      end
    end else if (prog_en && in_array(prog_addr)) begin
      cells_q[index_of(prog_addr)] <= cells_q[index_of(prog_addr)] & prog_data;
    end
  end

endmodule

// File: fpe_flash_program_erase_control.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
// Function
// (RULE1) erased bits read one, programmed bits read zero
// (RULE2) array decodes 16384 main bytes plus 48 vector bytes at top
// (RULE3) block erase clears one aligned 512-byte block of main region
// (RULE4) block erase never clears the vector region; only mass erase does
// (RULE5) high voltage sets only with program or erase selected and sequence armed
// (RULE6) high voltage bit drives charge pump and array high voltage
// (RULE7) with erase selected, mass bit picks mass versus block erase
// (RULE8) software never selects erase and program together
// (RULE9) block erase: select, write block, wait, hv, 10ms, deselect, wait, clear
// (RULE10) mass erase: select both, write vectors, hv, 200ms, deselect, 100us, clear
// (RULE11) programming confined to the latched 64-byte aligned row
// (RULE12) program select arms latching; bytes written 30us apart under hv
// (RULE13) normal reads resume 1us after high voltage clears
// (RULE14) software keeps step order; unrelated work between steps allowed
// (RULE15) sequence code runs from RAM, not from the array
// (RULE16) protected target keeps high voltage off
// (RULE17) protect start is register bits 7..1 as address bits 15..9
// (RULE18) protect zero guards all, all ones guards nothing
// (RULE19) array writes with nothing selected change nothing
// (RULE20) protect register resets to zero, whole array protected
module fpe_flash_program_erase_control
  import fpe_pkg::*;
(
  input  wire logic        clock,                // 10 MHz system clock
  input  wire logic        reset,                // synchronous, active high
  input  wire logic [15:0] bus_addr,             // register or array address
  input  wire logic [7:0]  bus_wdata,            // write data
  input  wire logic        bus_write,            // write strobe
  input  wire logic        bus_read,             // read strobe
  output logic [7:0]       bus_rdata,            // read data, cycle after strobe
  output logic             charge_pump_on,       // pump running
  output logic             high_voltage_to_array,// hv applied to array
  output logic             array_busy            // array not readable
);

  fpe_bus_type bus;
  assign bus = '{write: bus_write, read: bus_read, addr: bus_addr, wdata: bus_wdata};

  logic [7:0]  control_q;
  logic [7:0]  protect_start_q;
  logic        armed_q;
  logic [15:0] target_q;
  logic        erase_done_q;
  logic        hv_prev_q;
  logic [7:0]  recovery_q;
  logic [1:0]  rsel_q;
  logic        target_protected;
  logic        array_hit;
  logic        reg_read_q;
  logic [7:0]  reg_rdata_q;
  logic [7:0]  array_rdata;
  fpe_op_type  op;

  logic program_select;
  logic erase_select;
  logic mass_select;
  logic high_voltage_enable;

  assign program_select      = control_q[PROG_BIT];
  assign erase_select        = control_q[ERASE_BIT];
  assign mass_select         = control_q[MASS_BIT];
  assign high_voltage_enable = control_q[HIGH_VOLTAGE_ENABLE_BIT];

  assign array_hit = (bus.addr >= MAIN_LO && bus.addr <= MAIN_HI) || (bus.addr >= VEC_LO);

  // (RULE7) operation decode
  always_comb begin
    if (program_select && !erase_select) begin
      op = FPE_OP_PROGRAM;
    end else if (erase_select && !program_select) begin
      op = mass_select ? FPE_OP_MASS : FPE_OP_BLOCK;
    end else begin
      op = FPE_OP_NONE;
    end
  end

  fpe_protect u_protect (
    .protect_start_bits (protect_start_q),
    .target_addr        (target_q),
    .target_protected   (target_protected)
  );

  // (RULE20) protect register resets to zero
  always_ff @(posedge clock) begin
    if (reset) begin
      protect_start_q <= PROTECT_RESET;
    end else if (bus.write && bus.addr == PROTECT_ADDR) begin
      protect_start_q <= bus.wdata;
    end
  end

  // control register; hv bit gated by arming and protection
  always_ff @(posedge clock) begin
    if (reset) begin
      control_q <= CONTROL_RESET;
    end else if (bus.write && bus.addr == CONTROL_ADDR) begin
      control_q[PROG_BIT]  <= bus.wdata[PROG_BIT];
      control_q[ERASE_BIT] <= bus.wdata[ERASE_BIT];
      control_q[MASS_BIT]  <= bus.wdata[MASS_BIT];
      control_q[7:4]       <= 4'h0;
      if (!bus.wdata[HIGH_VOLTAGE_ENABLE_BIT]) begin
        control_q[HIGH_VOLTAGE_ENABLE_BIT] <= 1'b0;
      // (RULE5) set only when selected and armed
      end else if ((program_select || erase_select) && armed_q
                   // (RULE16) refuse when target protected
                   && !target_protected) begin
        control_q[HIGH_VOLTAGE_ENABLE_BIT] <= 1'b1;
      end
    end
  end

  // (RULE12) arming latch of target address
  always_ff @(posedge clock) begin
    if (reset) begin
      armed_q  <= 1'b0;
      target_q <= 16'h0000;
    end else if (op == FPE_OP_NONE) begin
      armed_q <= 1'b0;
    // (RULE19) writes ignored when nothing selected
    end else if (bus.write && array_hit && !armed_q && !high_voltage_enable) begin
      // (RULE4) block erase target must lie in main region
      if (op != FPE_OP_BLOCK || bus.addr <= MAIN_HI) begin
        // (RULE10) mass erase armed by any array write
        armed_q  <= 1'b1;
        target_q <= bus.addr;
      end
    end
  end

  // program pulses: bytes land only inside the latched row
  logic prog_pulse;
  // (RULE11) byte must share the latched row
  assign prog_pulse = bus.write && array_hit && op == FPE_OP_PROGRAM && high_voltage_enable
                      && (bus.addr >> ROW_SHIFT) == (target_q >> ROW_SHIFT);

  // erase fires once when hv rises in an erase mode
  logic erase_pulse;
  // (RULE9) erase applied under high voltage
  assign erase_pulse = high_voltage_enable && !erase_done_q &&
                       (op == FPE_OP_BLOCK || op == FPE_OP_MASS);

  always_ff @(posedge clock) begin
    if (reset) begin
      erase_done_q <= 1'b0;
    end else if (!high_voltage_enable) begin
      erase_done_q <= 1'b0;
    end else if (erase_pulse) begin
      erase_done_q <= 1'b1;
    end
  end

  fpe_array u_array (
    .clock      (clock),
    .reset      (reset),
    .rd_en      (bus.read),
    .rd_addr    (bus.addr),
    .rd_data    (array_rdata),
    .prog_en    (prog_pulse),
    .prog_addr  (bus.addr),
    .prog_data  (bus.wdata),
    .erase_en   (erase_pulse),
    .erase_mass (op == FPE_OP_MASS),
    .erase_addr (target_q)
  );

  // (RULE13) recovery count after hv clears
  always_ff @(posedge clock) begin
    if (reset) begin
      hv_prev_q  <= 1'b0;
      recovery_q <= 8'h00;
    end else begin
      hv_prev_q <= high_voltage_enable;
      if (hv_prev_q && !high_voltage_enable) begin
        // hv_prev_q already covers the first low cycle, so load one less
        recovery_q <= 8'(RECOVERY_CYCLES - 1);
      end else if (recovery_q != 8'h00) begin
        recovery_q <= recovery_q - 8'h01;
      end
    end
  end

  // (RULE6) pump and array hv follow the bit
  assign charge_pump_on        = high_voltage_enable;
  assign high_voltage_to_array = high_voltage_enable;
  // no readable gap between hv clearing and the recovery count starting
  assign array_busy            = high_voltage_enable || hv_prev_q || (recovery_q != 8'h00);

  // register read path; array reads blank while busy
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_read_q  <= 1'b0;
      reg_rdata_q <= 8'h00;
      rsel_q      <= 2'd0;
    end else begin
      reg_read_q <= bus.read;
      if (bus.read) begin
        if (bus.addr == CONTROL_ADDR) begin
          reg_rdata_q <= control_q;
          rsel_q      <= 2'd1;
        end else if (bus.addr == PROTECT_ADDR) begin
          reg_rdata_q <= protect_start_q;
          rsel_q      <= 2'd1;
        end else if (array_hit && !array_busy) begin
          reg_rdata_q <= 8'h00;
          rsel_q      <= 2'd2;
        end else begin
          reg_rdata_q <= 8'h00;
          rsel_q      <= 2'd0;
        end
      end
    end
  end

  always_comb begin
    if (!reg_read_q) begin
      bus_rdata = 8'h00;
    end else if (rsel_q == 2'd2) begin
      bus_rdata = array_rdata;
    end else begin
      bus_rdata = reg_rdata_q;
    end
  end

endmodule

// File: fpe_checker.sv
`timescale 1ns/10ps
module fpe_checker
  import fpe_pkg::*;
(
  input wire logic        clock,                 // system clock
  input wire logic        reset,                 // sync reset
  input wire logic [15:0] bus_addr,              // address
  input wire logic [7:0]  bus_wdata,             // write data
  input wire logic        bus_write,             // write strobe
  input wire logic        bus_read,              // read strobe
  input wire logic [7:0]  bus_rdata,             // read data
  input wire logic        charge_pump_on,        // pump
  input wire logic        high_voltage_to_array, // hv
  input wire logic        array_busy             // busy
);
  logic in_array;
  logic ctrl_w;
  assign in_array = (bus_addr >= MAIN_LO && bus_addr <= MAIN_HI) || bus_addr >= VEC_LO;
  assign ctrl_w   = bus_write && bus_addr == CONTROL_ADDR;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // recovery tail spans ten cycles; slack of one either way
  sequence busy_tail;
    array_busy [*8] ##1 array_busy ##[1:3] !array_busy;
  endsequence
  sequence busy_read;
    bus_read && in_array && array_busy ##1 array_busy;
  endsequence
  AST_PUMP_HV: assert property (charge_pump_on == high_voltage_to_array)
    else $error("pump and hv differ");
  AST_HV_RISE: assert property ($rose(high_voltage_to_array) |-> $past(ctrl_w && bus_wdata[HIGH_VOLTAGE_ENABLE_BIT]))
    else $error("hv rose without a control write");
  AST_HV_HOLD: assert property (!ctrl_w |=> $stable(high_voltage_to_array))
    else $error("hv moved without a control write");
  AST_HV_CLR: assert property (ctrl_w && !bus_wdata[HIGH_VOLTAGE_ENABLE_BIT] |=> !high_voltage_to_array)
    else $error("hv stayed on after clear");
  AST_HV_BUSY: assert property (high_voltage_to_array |-> array_busy)
    else $error("array readable under hv");
  AST_RECOVER: assert property ($fell(high_voltage_to_array) |-> busy_tail)
    else $error("recovery time wrong");
  AST_BUSY_RD: assert property (busy_read |-> bus_rdata == 8'h00)
    else $error("busy read not zero");
  AST_RD_IDLE: assert property (!$past(bus_read) |-> bus_rdata == 8'h00)
    else $error("read data outside answer cycle");
  AST_CTRL_RD: assert property (bus_read && bus_addr == CONTROL_ADDR |=>
    bus_rdata[7:4] == 4'h0 && bus_rdata[HIGH_VOLTAGE_ENABLE_BIT] == high_voltage_to_array)
    else $error("control readback wrong");
endmodule
bind fpe_flash_program_erase_control fpe_checker chk_i (.clock(clock), .reset(reset), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
  .charge_pump_on(charge_pump_on), .high_voltage_to_array(high_voltage_to_array), .array_busy(array_busy));

// File: fpe_pump_model.sv
`timescale 1ns/10ps
module fpe_pump_model (
  input  wire logic clock,                 // system clock
  input  wire logic reset,                 // sync reset
  input  wire logic charge_pump_on,        // pump request
  input  wire logic high_voltage_to_array, // hv switch
  output logic      pump_ready             // hv at working level
);
  logic [3:0] ramp_q;
  // pump ramps while on, collapses at once when off
  always_ff @(posedge clock) begin
    if (reset || !charge_pump_on) ramp_q <= 4'h0;
    else if (ramp_q != 4'hf) ramp_q <= ramp_q + 4'h1;
  end
  assign pump_ready = high_voltage_to_array && ramp_q[3];
endmodule

// File: fpe_flash_program_erase_control_tb_top.sv
`timescale 1ns/10ps
module fpe_flash_program_erase_control_tb_top;
  import fpe_pkg::*;
  logic        clock;
  logic        reset;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_write;
  logic        bus_read;
  logic [7:0]  bus_rdata;
  logic        pump;
  logic        hv;
  logic        busy;
  logic        pump_ready;
  logic [7:0]  v;
  int          err_count;
  int          samples_checked;
  int          cycles;
  fpe_flash_program_erase_control dut (.clock(clock), .reset(reset), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .charge_pump_on(pump), .high_voltage_to_array(hv), .array_busy(busy));
  fpe_pump_model pump_i (.clock(clock), .reset(reset), .charge_pump_on(pump),
    .high_voltage_to_array(hv), .pump_ready(pump_ready));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clock);
    bus_write <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clock);
    bus_read <= 1'b0;
    #50 d = bus_rdata;
  endtask
  // one full select, arm, hv, deselect sequence; ok says whether hv may rise
  task automatic op(input logic [7:0] sel, input logic [15:0] tgt, input logic [7:0] dat, input logic ok);
    logic [7:0] r;
    // bench drives steps, no array fetch
    wr(CONTROL_ADDR, sel);
    wr(tgt, 8'hff);
    wr(CONTROL_ADDR, sel | 8'h08);
    #1 chk({7'h00, pump}, {7'h00, ok});
    if (ok) begin
      rd(tgt, r);
      chk(r, 8'h00);
      repeat (8) @(posedge clock);
      #1 chk({7'h00, pump_ready}, 8'h01);
    end
    if (sel[PROG_BIT]) begin
      wr(tgt, dat);
      wr(tgt ^ 16'h0040, 8'h00);
    end
    wr(CONTROL_ADDR, 8'h08);
    wr(CONTROL_ADDR, 8'h00);
    repeat (14) @(posedge clock);
  endtask
  task automatic expect_rd(input logic [15:0] a, input logic [7:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    reset = 1'b1;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_write = 1'b0;
    bus_read = 1'b0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    expect_rd(CONTROL_ADDR, CONTROL_RESET);
    expect_rd(PROTECT_ADDR, 8'h00);
    expect_rd(16'hfe0a, 8'h00);
    op(8'h02, 16'hc000, 8'h00, 1'b0);
    wr(PROTECT_ADDR, 8'hff);
    wr(CONTROL_ADDR, 8'h01);
    wr(CONTROL_ADDR, 8'h09);
    #1 chk({7'h00, pump}, 8'h00);
    wr(CONTROL_ADDR, 8'h00);
    op(8'h06, 16'hffd0, 8'h00, 1'b1);
    expect_rd(16'hc200, ERASED_BYTE);
    expect_rd(16'hffff, ERASED_BYTE);
    expect_rd(16'hfa00, 8'h00);
    op(8'h01, 16'hc040, 8'h5a, 1'b1);
    expect_rd(16'hc040, 8'h5a);
    expect_rd(16'hc000, 8'hff);
    wr(16'hc041, 8'h00);
    expect_rd(16'hc041, 8'hff);
    wr(PROTECT_ADDR, 8'hc2);
    op(8'h01, 16'hc200, 8'h00, 1'b0);
    expect_rd(16'hc200, 8'hff);
    op(8'h02, 16'hc040, 8'h00, 1'b1);
    expect_rd(16'hc040, 8'hff);
    wr(PROTECT_ADDR, 8'hff);
    op(8'h01, 16'hffd0, 8'h12, 1'b1);
    op(8'h02, 16'hffd0, 8'h00, 1'b0);
    expect_rd(16'hffd0, 8'h12);
    print_verdict;
  end
endmodule
